// >>> verilog/peak_hold_result_regs.sv
// Purpose: result, peak, hold and display-source registers of a meter converter
// Assumes: conversion results arrive with a one-cycle valid strobe on SYS_CLK
// Notes:   APB slave, zero wait states; unmapped addresses read zero, PSLVERR set
//
// Contract
// RQ1 - enabling peak loads current result first
// RQ2 - peak replaced only by larger result
// RQ3 - writing peak enable zero clears peak
// RQ4 - valid only inside documented count window
// RQ5 - peak is two's complement, variant dependent
// RQ6 - peak 16 bits, read-only, resets zero
// RQ7 - low register: four LSBs, upper nibble
// RQ8 - reset returns all registers to defaults
// RQ9 - auto offset calibration while control zero
// RQ10 - enhanced calibration bit triggers extra calibration
// RQ11 - independent digital and analog powerdown bits
// RQ12 - freeze keeps reading from set time
// RQ13 - peak enable shows peak on display
// RQ14 - low battery sets flag and annunciator
// RQ15 - negative display magnitude reduced by one
// RQ16 - display loads from result, peak, host
// RQ17 - main result upper 16 bits, read-only
// RQ18 - result equals calibrated minus custom offset
// RQ19 - peak comparison is signed
// RQ20 - results update only on conversion events
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module peak_hold_result_regs
  import peak_regs_pkg::*;
#(
  parameter int RAW_W = 20
) (
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // conversion engine
  input  wire logic              CONV_DONE,
  input  wire logic [RAW_W-1:0]  CONV_RAW,
  input  wire logic              CAL_DONE,
  output logic                   AUTO_CAL_EN,
  output logic                   ENH_CAL_START,
  output logic                   DIG_PD,
  output logic                   ANA_PD,
  // battery comparator pin
  input  wire logic              BATT_BELOW,
  // display
  output logic      [15:0]       DISP_VALUE,
  output logic                   DISP_NEG,
  output logic                   BATT_SEGMENT
);

  logic [CTRL_W-1:0] ctrl;
  logic [15:0]       cust_offset;
  logic [15:0]       result_hi;
  logic [7:0]        result_lo;
  logic [15:0]       peak;
  logic [15:0]       display;
  logic [15:0]       host_disp;
  logic              enh_busy;
  logic [2:0]        batt_sync;
  logic              battery_low_flag;
  logic [RAW_W-1:0]  next_result;
  logic              wr_en;
  logic              rd_en;
  logic              addr_ok;
  logic              peak_on;

  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && PENABLE && !PWRITE;
  assign PREADY  = 1'b1;
  assign peak_on = ctrl[CB_PEAK];

  always_comb begin
    case (PADDR)
      CTRL_OFS, STATUS_OFS, OFFSET_OFS, RESULT_OFS,
      LOWNIB_OFS, PEAK_OFS, DISPLAY_OFS: addr_ok = 1'b1;
      default:                           addr_ok = 1'b0;
    endcase
  end

  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // RQ8 control defaults
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= CTRL_RST;
    end else if (wr_en && PADDR == CTRL_OFS) begin
      ctrl <= PWDATA[CTRL_W-1:0];
    end else if (CAL_DONE) begin
      // enhanced request self-clears once the engine reports completion
      ctrl[CB_ENHCAL] <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cust_offset <= WORD_RST;
      host_disp   <= WORD_RST;
    end else if (wr_en) begin
      if (PADDR == OFFSET_OFS) begin
        cust_offset <= PWDATA[15:0];
      end
      if (PADDR == DISPLAY_OFS) begin
        host_disp <= PWDATA[15:0];
      end
    end
  end

  // RQ9 auto calibration while control bit clear
  assign AUTO_CAL_EN = !ctrl[CB_AUTOOFF];
  // RQ11 independent powerdown bits
  assign DIG_PD      = ctrl[CB_PDDIG];
  assign ANA_PD      = ctrl[CB_PDANA];

  // RQ10 enhanced calibration pulse
  // edge detect: a request bit left set does not restart the engine
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      enh_busy      <= 1'b0;
      ENH_CAL_START <= 1'b0;
    end else begin
      ENH_CAL_START <= ctrl[CB_ENHCAL] && !enh_busy;
      enh_busy      <= ctrl[CB_ENHCAL];
    end
  end

  // RQ18 subtract custom offset, aligned to result msbs
  assign next_result = CONV_RAW - {cust_offset, {(RAW_W-16){1'b0}}};

  // RQ20 update only on conversion events
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_hi <= WORD_RST;
      result_lo <= LOWNIB_RST;
    end else if (CONV_DONE) begin
      // RQ17 upper sixteen bits
      result_hi <= next_result[RAW_W-1 -: 16];
      // RQ7 low nibble in upper half
      result_lo <= {next_result[3:0], 4'h0};
    end
  end

  // RQ1 RQ3 peak load and clear; RQ4 out-of-window values not handled specially
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      peak <= WORD_RST;
    end else if (wr_en && PADDR == CTRL_OFS && !PWDATA[CB_PEAK]) begin
      // RQ3 clear on zero write
      peak <= WORD_RST;
    end else if (wr_en && PADDR == CTRL_OFS && PWDATA[CB_PEAK] && !peak_on) begin
      // RQ1 seed with current result
      // limitation: a result landing in this same cycle is not compared
      peak <= result_hi;
    end else if (peak_on && CONV_DONE &&
                 // RQ19 RQ2 signed greater test
                 $signed(next_result[RAW_W-1 -: 16]) > $signed(peak)) begin
      // RQ5 full 16-bit two's complement kept
      peak <= next_result[RAW_W-1 -: 16];
    end
  end

  // RQ16 display source select
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      display <= WORD_RST;
    end else if (ctrl[CB_FREEZE]) begin
      // RQ12 freeze keeps last reading
      display <= display;
    end else if (peak_on) begin
      // RQ13 show peak
      display <= peak;
    end else if (ctrl[CB_HOSTSRC]) begin
      display <= host_disp;
    end else begin
      display <= result_hi;
    end
  end

  // RQ15 negative shows magnitude minus one, i.e. bitwise inversion
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DISP_VALUE <= WORD_RST;
      DISP_NEG   <= 1'b0;
    end else begin
      DISP_NEG   <= display[15];
      DISP_VALUE <= display[15] ? ~display : display;
    end
  end

  // RQ14 battery flag from synchronised comparator
  // a level counts only once two stages agree, so a one-cycle glitch is dropped
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      batt_sync        <= 3'h0;
      battery_low_flag <= 1'b0;
    end else begin
      batt_sync <= {batt_sync[1:0], BATT_BELOW};
      if (batt_sync[2] == batt_sync[1]) begin
        battery_low_flag <= batt_sync[2];
      end
    end
  end

  assign BATT_SEGMENT = battery_low_flag;

  // RQ6 RQ7 read-only registers on read mux
  // latched in the setup phase so the word stands through the access phase
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        CTRL_OFS:    PRDATA <= {25'h0, ctrl};
        STATUS_OFS:  PRDATA <= {31'h0, battery_low_flag};
        OFFSET_OFS:  PRDATA <= {16'h0, cust_offset};
        RESULT_OFS:  PRDATA <= {16'h0, result_hi};
        LOWNIB_OFS:  PRDATA <= {24'h0, result_lo};
        PEAK_OFS:    PRDATA <= {16'h0, peak};
        DISPLAY_OFS: PRDATA <= {16'h0, display};
        default:     PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // register-side checks, all sampled on the bus clock
  chk_peak_monotonic: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ2
    peak_on && $past(peak_on) && !(wr_en && PADDR == CTRL_OFS) |->
    $signed(peak) >= $signed($past(peak))) else $error("peak decreased");
  chk_peak_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ3
    wr_en && PADDR == CTRL_OFS && !PWDATA[CB_PEAK] |=> peak == 16'h0000)
    else $error("peak not cleared");
  chk_peak_seed: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ1
    wr_en && PADDR == CTRL_OFS && PWDATA[CB_PEAK] && !peak_on |=>
    peak == $past(result_hi)) else $error("peak not seeded");
  chk_peak_ro: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ6
    wr_en && PADDR == PEAK_OFS && !peak_on |=> $stable(peak))
    else $error("peak written by host");
  chk_peak_readback: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ6
    PSEL && !PENABLE && !PWRITE && PADDR == PEAK_OFS |=>
    PRDATA == {16'h0000, $past(peak)}) else $error("peak read data wrong");
  chk_lownib_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ7
    result_lo[3:0] == 4'h0) else $error("low nibble not zero");
  chk_lownib_value: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ7
    CONV_DONE |=> result_lo[7:4] == $past(CONV_RAW[3:0]))
    else $error("low nibble not result lsbs");
  chk_lownib_readback: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ7
    PSEL && !PENABLE && !PWRITE && PADDR == LOWNIB_OFS |=>
    PRDATA == {24'h000000, $past(result_lo)}) else $error("low read data wrong");
  chk_result_stable: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ20
    !$past(CONV_DONE) |-> $stable(result_hi)) else $error("result changed");
  chk_result_calc: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ18
    CONV_DONE |=> result_hi == $past(CONV_RAW[RAW_W-1 -: 16]) - $past(cust_offset))
    else $error("result not offset corrected");
  chk_result_ro: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ17
    wr_en && PADDR == RESULT_OFS && !CONV_DONE |=> $stable(result_hi))
    else $error("result written by host");
  chk_freeze_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ12
    ctrl[CB_FREEZE] |=> $stable(display)) else $error("display moved");
  chk_peak_display: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ13
    !ctrl[CB_FREEZE] && peak_on |=> display == $past(peak))
    else $error("display not peak");
  chk_host_display: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ16
    !ctrl[CB_FREEZE] && !peak_on && ctrl[CB_HOSTSRC] |=> display == $past(host_disp))
    else $error("display not host data");
  chk_result_display: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ16
    !ctrl[CB_FREEZE] && !peak_on && !ctrl[CB_HOSTSRC] |=> display == $past(result_hi))
    else $error("display not result");
  chk_neg_display: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ15
    display == 16'hFFFF |=> DISP_NEG && DISP_VALUE == 16'h0000)
    else $error("minus one not minus zero");
  chk_pos_display: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ15
    !display[15] |=> !DISP_NEG && DISP_VALUE == $past(display))
    else $error("positive reading altered");
  chk_batt_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ14
    BATT_BELOW [*5] |-> battery_low_flag && BATT_SEGMENT)
    else $error("battery flag missing");
  chk_batt_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ14
    (!BATT_BELOW) [*5] |-> !battery_low_flag && !BATT_SEGMENT)
    else $error("battery flag stuck");
  chk_autocal: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ9
    wr_en && PADDR == CTRL_OFS |=> AUTO_CAL_EN == !$past(PWDATA[CB_AUTOOFF]))
    else $error("auto calibration enable wrong");
  chk_pd_split: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ11
    wr_en && PADDR == CTRL_OFS |=>
    DIG_PD == $past(PWDATA[CB_PDDIG]) && ANA_PD == $past(PWDATA[CB_PDANA]))
    else $error("powerdown mismatch");
  chk_enh_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ10
    $rose(ctrl[CB_ENHCAL]) |=> ENH_CAL_START ##1 !ENH_CAL_START)
    else $error("calibration start not one pulse");
  chk_cal_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ10
    CAL_DONE && !(wr_en && PADDR == CTRL_OFS) |=> !ctrl[CB_ENHCAL])
    else $error("calibration request not cleared");

  cov_peak_update: cover property (@(posedge SYS_CLK) peak_on && CONV_DONE ##1 $changed(peak));
  cov_freeze: cover property (@(posedge SYS_CLK) ctrl[CB_FREEZE] && CONV_DONE);
  cov_batt: cover property (@(posedge SYS_CLK) $rose(battery_low_flag));
  cov_enh_cal: cover property (@(posedge SYS_CLK) $rose(ENH_CAL_START));
  cov_host_neg: cover property (@(posedge SYS_CLK) ctrl[CB_HOSTSRC] && display == 16'hFFFF);

endmodule

// >>> verilog/peak_regs_pkg.sv
// Purpose: shared constants for the meter result register bank
// Assumes: APB, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package peak_regs_pkg;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STATUS_OFS   = 8'h04;
  localparam logic [7:0]  OFFSET_OFS   = 8'h08;
  localparam logic [7:0]  RESULT_OFS   = 8'h0C;
  localparam logic [7:0]  LOWNIB_OFS   = 8'h10;
  localparam logic [7:0]  PEAK_OFS     = 8'h14;
  localparam logic [7:0]  DISPLAY_OFS  = 8'h18;
  // control register bit positions
  localparam int          CB_PEAK      = 0;
  localparam int          CB_FREEZE    = 1;
  localparam int          CB_HOSTSRC   = 2;
  localparam int          CB_AUTOOFF   = 3;
  localparam int          CB_ENHCAL    = 4;
  localparam int          CB_PDDIG     = 5;
  localparam int          CB_PDANA     = 6;
  localparam int          CTRL_W       = 7;
  localparam logic [6:0]  CTRL_RST     = 7'h00;
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam logic [7:0]  LOWNIB_RST   = 8'h00;
  localparam logic [19:0] RAW_RST      = 20'h00000;
endpackage

// >>> test/conv_partner.sv
// Purpose: conversion engine stand-in that answers calibration requests
// Assumes: calibration start arrives as a one-cycle pulse
// Notes:   answer delay is a plain default, shortened for simulation
`timescale 1ns/1ps
module conv_partner #(
  parameter int CAL_CYC = 5
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // calibration handshake
  input  wire logic cal_start,
  output logic      cal_done
);
  int cnt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 0;
      cal_done <= 1'b0;
    end else begin
      cal_done <= (cnt == 1);
      if (cal_start)
        cnt <= CAL_CYC;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// >>> test/tb_top.sv
// Purpose: self-checking bench for the meter result register bank
// Assumes: zero-wait APB slave, results strobed by CONV_DONE
// Notes:   random results stay inside the peak count window
`timescale 1ns/1ps
module tb_top
  import peak_regs_pkg::*;
;
  logic        clk, rst_n, psel, pen, pwr, cdone, cal, batt, err, pkon;
  logic        prdy, perr, acen, ecs, dpd, apd, dn, bseg;
  logic        saw = 1'b0;
  logic [7:0]  padr;
  logic [31:0] pwd, prd, q;
  logic [19:0] craw, raw;
  logic [15:0] dv, ofs, res, pk, w;
  int          n_mismatch, checks, cyc, s;

  peak_hold_result_regs i_peak_hold_result_regs (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .CONV_DONE(cdone), .CONV_RAW(craw), .CAL_DONE(cal), .AUTO_CAL_EN(acen),
    .ENH_CAL_START(ecs), .DIG_PD(dpd), .ANA_PD(apd), .BATT_BELOW(batt),
    .DISP_VALUE(dv), .DISP_NEG(dn), .BATT_SEGMENT(bseg));
  conv_partner i_conv_partner (
    .sys_clk(clk), .rst_n(rst_n), .cal_start(ecs), .cal_done(cal));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= wr;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    q    = prd;
    err  = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic conv();
    s   = $urandom_range(38000) - 19000;
    raw = {s[15:0], 4'($urandom)};
    res = raw[19:4] - ofs;
    if (pkon && $signed(res) > $signed(pk))
      pk = res;
    @(posedge clk);
    cdone <= 1'b1;
    craw  <= raw;
    @(posedge clk);
    cdone <= 1'b0;
  endtask
  task automatic dchk(input logic [15:0] e);
    repeat (3) @(posedge clk);
    chk("display", {dn, dv}, {e[15], e[15] ? 16'(16'h0000 - e - 16'h0001) : e});
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (ecs === 1'b1)
      saw <= 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'hF807));
    {rst_n, psel, pen, pwr, cdone, batt, pkon, padr, pwd, craw, pk} = '0;
    ofs = 16'($urandom_range(15));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(PEAK_OFS, 32'h0, "peak reset");
    rd(LOWNIB_OFS, 32'h0, "low reset");
    chk("autocal", acen, 1'b1);
    bus(1'b1, PEAK_OFS, 32'hFFFF);
    rd(PEAK_OFS, 32'h0, "peak ro");
    rd(8'h20, 32'h0, "unmapped");
    chk("slverr", err, 1'b1);
    bus(1'b1, OFFSET_OFS, {16'h0, ofs});
    for (int i = 0; i < 6; i++) begin
      conv();
      rd(RESULT_OFS, {16'h0, res}, "result");
      rd(LOWNIB_OFS, {24'h0, raw[3:0], 4'h0}, "low nibble");
      dchk(res);
    end
    bus(1'b1, CTRL_OFS, 32'h1);
    pkon = 1'b1;
    pk   = res;
    rd(PEAK_OFS, {16'h0, pk}, "peak start");
    for (int i = 0; i < 8; i++) begin
      conv();
      rd(PEAK_OFS, {16'h0, pk}, "peak");
      dchk(pk);
    end
    bus(1'b1, CTRL_OFS, 32'h0);
    pkon = 1'b0;
    pk   = 16'h0;
    rd(PEAK_OFS, 32'h0, "peak clear");
    conv();
    w = res;
    bus(1'b1, CTRL_OFS, 32'h2);
    conv();
    dchk(w);
    bus(1'b1, CTRL_OFS, 32'h4);
    bus(1'b1, DISPLAY_OFS, 32'hFFFF);
    dchk(16'hFFFF);
    bus(1'b1, CTRL_OFS, 32'h68);
    @(posedge clk);
    chk("power bits", {acen, dpd, apd}, 3'b011);
    bus(1'b1, CTRL_OFS, 32'h20);
    @(posedge clk);
    chk("power bits", {acen, dpd, apd}, 3'b110);
    bus(1'b1, CTRL_OFS, 32'h50);
    repeat (12) @(posedge clk);
    chk("cal start", saw, 1'b1);
    chk("power bits", {acen, dpd, apd}, 3'b101);
    rd(CTRL_OFS, 32'h40, "cal clear");
    batt <= 1'b1;
    repeat (6) @(posedge clk);
    rd(STATUS_OFS, 32'h1, "batt flag");
    chk("batt segment", bseg, 1'b1);
    batt <= 1'b0;
    bus(1'b1, CTRL_OFS, 32'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(CTRL_OFS, 32'h0, "ctrl reset");
    rd(STATUS_OFS, 32'h0, "status reset");
    rd(PEAK_OFS, 32'h0, "peak after reset");
    rd(RESULT_OFS, 32'h0, "result after reset");
    end_of_test();
  end
endmodule
